// [hdl/ucrs_consts.svh]
// Register offsets, field positions and reset values of the clocked serial port
`ifndef UCRS_CONSTS_SVH
`define UCRS_CONSTS_SVH

`define UCRS_ADDR_RCSTA   3'h0
`define UCRS_ADDR_RCDATA  3'h1
`define UCRS_ADDR_TXSTA   3'h2
`define UCRS_ADDR_BAUD    3'h3
`define UCRS_ADDR_DIV_HI  3'h4
`define UCRS_ADDR_DIV_LO  3'h5
`define UCRS_ADDR_TXDATA  3'h6
`define UCRS_ADDR_IRQ     3'h7

`define UCRS_BAUD_WIDE_BIT 3
`define UCRS_IRQ_RXIE_BIT  0
`define UCRS_IRQ_TXIE_BIT  1
`define UCRS_IRQ_RXF_BIT   4
`define UCRS_IRQ_TXF_BIT   5

`define UCRS_RST_BYTE     8'h00
`define UCRS_NBITS_8      4'h8
`define UCRS_NBITS_9      4'h9

`endif

// [hdl/ucrs_pkg.sv]
// Types of the clocked serial port
package ucrs_pkg;

	typedef struct packed {
		logic serial_port_enable;
		logic nine_bit_receive_select;
		logic single_receive_enable;
		logic continuous_receive_enable;
		logic addr_detect;
		logic framing_error_flag;
		logic overrun_error_flag;
		logic received_ninth_bit;
	} ucrs_rcsta_t;

	typedef struct packed {
		logic clock_source_master_select;
		logic nine_bit_transmit_select;
		logic transmit_enable;
		logic sync_mode;
		logic send_break;
		logic high_rate;
		logic shift_register_empty_flag;
		logic transmit_ninth_bit;
	} ucrs_txsta_t;

	typedef struct packed {
		logic out;
		logic oe;
	} ucrs_pin_t;

	typedef enum logic {
		TX_IDLE  = 1'b0,
		TX_SHIFT = 1'b1
	} ucrs_tx_state_t;

endpackage

// [hdl/ucrs_top.sv]
// Clocked serial port: master and slave shifting, registers, sleep wake
`timescale 1ns/100ps
`include "ucrs_consts.svh"
module ucrs_top #(
	parameter int DIV_W = 16
) (
	// Clock and reset
	input  wire logic          clk,
	input  wire logic          rst_n,
	// Register port
	input  wire logic [2:0]    addr,
	input  wire logic [7:0]    wdata,
	input  wire logic          wr,
	input  wire logic          rd,
	output logic      [7:0]    rdata,
	// Core power state
	input  wire logic          core_sleep,
	// Shift clock pin
	input  wire logic          shift_clock_pin_in,
	output ucrs_pkg::ucrs_pin_t shift_clock_pin,
	// Data pin
	input  wire logic          receive_data_pin_in,
	output ucrs_pkg::ucrs_pin_t receive_data_pin,
	// Requests to the core
	output logic               rx_irq,
	output logic               tx_irq,
	output logic               wake_request
);

	if (DIV_W < 9 || DIV_W > 16) begin : g_chk
		$error("DIV_W must lie between 9 and 16");
	end

	ucrs_pkg::ucrs_rcsta_t     rc, next_rc;
	ucrs_pkg::ucrs_txsta_t     ts, next_ts;
	ucrs_pkg::ucrs_tx_state_t  tx_state, next_tx_state;
	logic [7:0]                div_lo, next_div_lo;
	logic [7:0]                div_hi, next_div_hi;
	logic [7:0]                rx_data, next_rx_data;
	logic [7:0]                tx_buf, next_tx_buf;
	logic [7:0]                next_rdata;
	logic                      div16, next_div16;
	logic                      rx_ie, next_rx_ie;
	logic                      tx_ie, next_tx_ie;
	logic                      rx_flag, next_rx_flag;
	logic                      tx_full, next_tx_full;
	logic [8:0]                rsr, next_rsr;
	logic [3:0]                rx_cnt, next_rx_cnt;
	logic [8:0]                transmit_shift_register, next_tsr;
	logic [3:0]                tx_cnt, next_tx_cnt;
	logic                      tx_started, next_tx_started;
	logic [DIV_W-1:0]          bcnt, next_bcnt;
	logic [DIV_W-1:0]          divisor;
	logic                      mclk, next_mclk;
	logic [2:0]                ck_s, next_ck_s;
	logic [2:0]                dt_s, next_dt_s;
	logic                      ck_lvl, next_ck_lvl;
	logic                      dt_lvl, next_dt_lvl;
	logic                      ck_prev;

	logic port_on, master, sync_on, cont_en, single_en, tx_en, ovr;
	logic rx_on, m_on, m_tick, rise_ev, fall_ev;
	logic rx_word, unread, ok_word, load, wr_tx, rd_rx;

	assign port_on   = rc.serial_port_enable & ts.sync_mode;
	assign master    = ts.clock_source_master_select;
	assign sync_on   = ts.sync_mode;
	assign cont_en   = rc.continuous_receive_enable;
	assign single_en = rc.single_receive_enable;
	assign tx_en     = ts.transmit_enable;
	assign ovr       = rc.overrun_error_flag;
	assign wr_tx     = wr && addr == `UCRS_ADDR_TXDATA;
	assign rd_rx     = rd && addr == `UCRS_ADDR_RCDATA;

	// Single enable is ignored in slave operation; master receive is held off while a word shifts out
	assign rx_on = port_on & ~ovr & (cont_en | (master & single_en)) &
		~(master & tx_state == ucrs_pkg::TX_SHIFT);

	// Pin synchronisers; a level counts once the last two stages agree
	always_comb begin
		next_ck_s   = {ck_s[1:0], shift_clock_pin_in};
		next_dt_s   = {dt_s[1:0], receive_data_pin_in};
		next_ck_lvl = (ck_s[1] == ck_s[2]) ? ck_s[2] : ck_lvl;
		next_dt_lvl = (dt_s[1] == dt_s[2]) ? dt_s[2] : dt_lvl;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ck_s    <= 3'h0;
			dt_s    <= 3'h0;
			ck_lvl  <= 1'b0;
			dt_lvl  <= 1'b0;
			ck_prev <= 1'b0;
		end else begin
			ck_s    <= next_ck_s;
			dt_s    <= next_dt_s;
			ck_lvl  <= next_ck_lvl;
			dt_lvl  <= next_dt_lvl;
			ck_prev <= ck_lvl;
		end
	end

	// Master clock generator; it stops in sleep since it runs off the core clock
	assign divisor = div16 ? {div_hi[DIV_W-9:0], div_lo} : {{(DIV_W-8){1'b0}}, div_lo};
	assign m_on    = port_on & master & ~core_sleep &
		(tx_state == ucrs_pkg::TX_SHIFT | rx_on);
	assign m_tick  = m_on && bcnt == divisor;

	always_comb begin
		next_bcnt = bcnt;
		next_mclk = mclk;
		if (!m_on) begin
			next_bcnt = '0;
			next_mclk = 1'b0;
		end else if (m_tick) begin
			next_bcnt = '0;
			next_mclk = ~mclk;
		end else begin
			next_bcnt = bcnt + 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bcnt <= '0;
			mclk <= 1'b0;
		end else begin
			bcnt <= next_bcnt;
			mclk <= next_mclk;
		end
	end

	// Slave edges come only from the pin and do not depend on sleep
	always_comb begin
		if (master) begin
			rise_ev = m_tick & ~mclk;
			fall_ev = m_tick & mclk;
		end else begin
			rise_ev = port_on & ck_lvl & ~ck_prev;
			fall_ev = port_on & ~ck_lvl & ck_prev;
		end
	end

	// Receive shifter
	always_comb begin
		next_rsr    = rsr;
		next_rx_cnt = rx_cnt;
		rx_word     = 1'b0;
		if (!rx_on) begin
			next_rx_cnt = 4'h0;
		end else if (fall_ev) begin
			next_rsr[rx_cnt] = dt_lvl;
			if (rx_cnt == (rc.nine_bit_receive_select ? `UCRS_NBITS_9 : `UCRS_NBITS_8) - 4'h1) begin
				rx_word     = 1'b1;
				next_rx_cnt = 4'h0;
			end else begin
				next_rx_cnt = rx_cnt + 4'h1;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rsr    <= 9'h000;
			rx_cnt <= 4'h0;
		end else begin
			rsr    <= next_rsr;
			rx_cnt <= next_rx_cnt;
		end
	end

	// Transmit shifter; the bit stands from load, moves on each rise after the first fall
	assign load = tx_state == ucrs_pkg::TX_IDLE && tx_full && tx_en && port_on &&
		!(master && rx_on);

	always_comb begin
		next_tx_state   = tx_state;
		next_tsr        = transmit_shift_register;
		next_tx_cnt     = tx_cnt;
		next_tx_started = tx_started;
		if (load) begin
			next_tx_state   = ucrs_pkg::TX_SHIFT;
			next_tsr        = {ts.transmit_ninth_bit, tx_buf};
			next_tx_cnt     = ts.nine_bit_transmit_select ? `UCRS_NBITS_9 : `UCRS_NBITS_8;
			next_tx_started = 1'b0;
		end else if (tx_state == ucrs_pkg::TX_SHIFT) begin
			if (!tx_en || !port_on) begin
				next_tx_state = ucrs_pkg::TX_IDLE;
			end else if (fall_ev) begin
				next_tx_started = 1'b1;
				next_tx_cnt     = tx_cnt - 4'h1;
				if (tx_cnt == 4'h1) begin
					next_tx_state = ucrs_pkg::TX_IDLE;
				end
			end else if (rise_ev && tx_started) begin
				next_tsr = {1'b0, transmit_shift_register[8:1]};
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_state   <= ucrs_pkg::TX_IDLE;
			transmit_shift_register        <= 9'h000;
			tx_cnt     <= 4'h0;
			tx_started <= 1'b0;
		end else begin
			tx_state   <= next_tx_state;
			transmit_shift_register        <= next_tsr;
			tx_cnt     <= next_tx_cnt;
			tx_started <= next_tx_started;
		end
	end

	// Register file; hardware events are applied after software writes so they win
	assign unread  = rx_flag & ~rd_rx;
	assign ok_word = rx_word & ~unread;

	always_comb begin
		next_rc      = rc;
		next_ts      = ts;
		next_div_lo  = div_lo;
		next_div_hi  = div_hi;
		next_div16   = div16;
		next_rx_ie   = rx_ie;
		next_tx_ie   = tx_ie;
		next_rx_data = rx_data;
		next_tx_buf  = tx_buf;
		next_rdata   = `UCRS_RST_BYTE;
		if (wr) begin
			if (addr == `UCRS_ADDR_RCSTA) begin
				next_rc.serial_port_enable        = wdata[7];
				next_rc.nine_bit_receive_select   = wdata[6];
				next_rc.single_receive_enable     = wdata[5];
				next_rc.continuous_receive_enable = wdata[4];
				if (!wdata[4]) begin
					next_rc.overrun_error_flag = 1'b0;
				end
			end else if (addr == `UCRS_ADDR_TXSTA) begin
				next_ts = ucrs_pkg::ucrs_txsta_t'(wdata & 8'hf1);
			end else if (addr == `UCRS_ADDR_BAUD) begin
				next_div16 = wdata[`UCRS_BAUD_WIDE_BIT];
			end else if (addr == `UCRS_ADDR_DIV_HI) begin
				next_div_hi = wdata;
			end else if (addr == `UCRS_ADDR_DIV_LO) begin
				next_div_lo = wdata;
			end else if (addr == `UCRS_ADDR_TXDATA) begin
				next_tx_buf = wdata;
			end else if (addr == `UCRS_ADDR_IRQ) begin
				next_rx_ie = wdata[`UCRS_IRQ_RXIE_BIT];
				next_tx_ie = wdata[`UCRS_IRQ_TXIE_BIT];
			end
		end
		if (ok_word) begin
			next_rx_data = next_rsr[7:0];
			next_rc.received_ninth_bit = rc.nine_bit_receive_select & next_rsr[8];
			if (!cont_en) begin
				next_rc.single_receive_enable = 1'b0;
			end
		end
		if (rx_word && unread) begin
			next_rc.overrun_error_flag = 1'b1;
		end
		if (rd) begin
			if (addr == `UCRS_ADDR_RCSTA) begin
				next_rdata = rc;
			end else if (addr == `UCRS_ADDR_RCDATA) begin
				next_rdata = rx_data;
			end else if (addr == `UCRS_ADDR_TXSTA) begin
				next_rdata    = ts;
				next_rdata[1] = tx_state == ucrs_pkg::TX_IDLE;
			end else if (addr == `UCRS_ADDR_BAUD) begin
				next_rdata[`UCRS_BAUD_WIDE_BIT] = div16;
			end else if (addr == `UCRS_ADDR_DIV_HI) begin
				next_rdata = div_hi;
			end else if (addr == `UCRS_ADDR_DIV_LO) begin
				next_rdata = div_lo;
			end else if (addr == `UCRS_ADDR_TXDATA) begin
				next_rdata = tx_buf;
			end else if (addr == `UCRS_ADDR_IRQ) begin
				next_rdata[`UCRS_IRQ_RXIE_BIT] = rx_ie;
				next_rdata[`UCRS_IRQ_TXIE_BIT] = tx_ie;
				next_rdata[`UCRS_IRQ_RXF_BIT]  = rx_flag;
				next_rdata[`UCRS_IRQ_TXF_BIT]  = ~tx_full;
			end
		end
	end

	// A write in the cycle of a hand-over refills the buffer, so the flag stays clear
	assign next_rx_flag = unread | ok_word;
	assign next_tx_full = (tx_full & ~load) | wr_tx;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rc      <= ucrs_pkg::ucrs_rcsta_t'(`UCRS_RST_BYTE);
			ts      <= ucrs_pkg::ucrs_txsta_t'(`UCRS_RST_BYTE);
			div_lo  <= `UCRS_RST_BYTE;
			div_hi  <= `UCRS_RST_BYTE;
			rx_data <= `UCRS_RST_BYTE;
			tx_buf  <= `UCRS_RST_BYTE;
			rdata   <= `UCRS_RST_BYTE;
			div16   <= 1'b0;
			rx_ie   <= 1'b0;
			tx_ie   <= 1'b0;
			rx_flag <= 1'b0;
			tx_full <= 1'b0;
		end else begin
			rc      <= next_rc;
			ts      <= next_ts;
			div_lo  <= next_div_lo;
			div_hi  <= next_div_hi;
			rx_data <= next_rx_data;
			tx_buf  <= next_tx_buf;
			rdata   <= next_rdata;
			div16   <= next_div16;
			rx_ie   <= next_rx_ie;
			tx_ie   <= next_tx_ie;
			rx_flag <= next_rx_flag;
			tx_full <= next_tx_full;
		end
	end

	// Pins and requests
	assign shift_clock_pin.out  = mclk;
	assign shift_clock_pin.oe   = port_on & master;
	assign receive_data_pin.out = transmit_shift_register[0];
	assign receive_data_pin.oe  = port_on & tx_state == ucrs_pkg::TX_SHIFT;
	assign rx_irq       = rx_flag & rx_ie;
	assign tx_irq       = ~tx_full & tx_ie;
	assign wake_request = core_sleep & (rx_irq | tx_irq);

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	sequence s_last_bit;
		tx_state == ucrs_pkg::TX_SHIFT && fall_ev && tx_cnt == 4'h1 && tx_full &&
			tx_en && port_on && !(master && (cont_en || single_en)) && !wr;
	endsequence

	sequence s_hand_over;
		tx_state == ucrs_pkg::TX_IDLE ##1 tx_state == ucrs_pkg::TX_SHIFT && !tx_full;
	endsequence

	rx_start_a: assert property (
		wr && addr == `UCRS_ADDR_RCSTA && wdata[7] && wdata[4] && sync_on && !ovr &&
			tx_state == ucrs_pkg::TX_IDLE && !load && !rx_word |=> rx_on)
		else $error("receive did not start on enable");

	fall_only_a: assert property (
		rx_on && !fall_ev |=> rx_cnt == $past(rx_cnt) || !rx_on)
		else $error("receive counter moved without a falling edge");

	single_stop_a: assert property (
		ok_word && !cont_en && !wr |=> !single_en && !rx_on)
		else $error("single receive did not stop");

	cont_keep_a: assert property (
		ok_word && cont_en && !wr |=> cont_en && single_en == $past(single_en))
		else $error("continuous receive was altered by a word");

	rx_done_a: assert property (
		ok_word && rx_ie |=> rx_flag && rx_irq && rx_data == $past(next_rsr[7:0]))
		else $error("received word not flagged or stored");

	ninth_a: assert property (
		ok_word |=> rc.received_ninth_bit == $past(rc.nine_bit_receive_select & next_rsr[8]))
		else $error("ninth bit wrong");

	err_clear_a: assert property (
		wr && addr == `UCRS_ADDR_RCSTA && !wdata[4] && !rx_word |=> !ovr)
		else $error("error not cleared with continuous enable");

	overrun_a: assert property (
		rx_word && unread |=> ovr && rx_flag && rx_data == $past(rx_data) ##1 !rx_word)
		else $error("overrun not handled");

	hold_second_a: assert property (
		tx_state == ucrs_pkg::TX_SHIFT && tx_full |=> tx_full)
		else $error("buffered word left early");

	hand_over_a: assert property (
		s_last_bit |=> s_hand_over)
		else $error("second word not handed over");

	no_tx_a: assert property (
		!tx_en |=> tx_state == ucrs_pkg::TX_IDLE ##1 tx_state == ucrs_pkg::TX_IDLE || tx_en)
		else $error("shifting without transmit enable");

endmodule // ucrs_top

// [sim/ucrs_peer.sv]
// Clocked serial peer: answers a master clock with words, or supplies a slave clock
`timescale 1ns/100ps
module ucrs_peer (
	// Device side of the pins
	input  wire logic dev_clk_out,
	input  wire logic dev_clk_oe,
	input  wire logic dev_dat_out,
	input  wire logic dev_dat_oe,
	// Resolved wires
	output wire logic clk_wire,
	output wire logic dat_wire
);
	logic       slv_clk;
	logic       fell;
	logic [8:0] words [3];
	int         nbits;
	int         widx;
	int         bidx;

	initial begin
		slv_clk = 1'b0;
		fell = 1'b0;
		widx = 3;
		bidx = 0;
		nbits = 8;
	end
	// Slave clock stands low outside frames
	assign clk_wire = dev_clk_oe ? dev_clk_out : slv_clk;
	// Data line has a pull-up once the peer runs out of words
	assign dat_wire = dev_dat_oe ? dev_dat_out : ((widx < 3) ? words[widx][bidx] : 1'b1);

	task automatic load(input logic [8:0] w0, input logic [8:0] w1, input logic [8:0] w2,
		input int n);
		words[0] = w0;
		words[1] = w1;
		words[2] = w2;
		nbits = n;
		widx = 0;
		bidx = 0;
		fell = 1'b0;
	endtask

	// Data changes at a rise so it is settled long before the sampling fall
	always @(negedge clk_wire) begin
		if (dev_clk_oe)
			fell <= 1'b1;
	end
	always @(posedge clk_wire) begin
		if (dev_clk_oe && fell) begin
			fell <= 1'b0;
			if (bidx == nbits - 1) begin
				bidx <= 0;
				widx <= widx + 1;
			end else
				bidx <= bidx + 1;
		end
	end

	// Peer samples late in the low phase, after the device has shifted
	task automatic slave_frame(input int nb, output logic [8:0] rx);
		rx = 9'h000;
		#100;
		for (int i = 0; i < nb; i++) begin
			slv_clk = 1'b1;
			#100 slv_clk = 1'b0;
			#60 rx[i] = dat_wire;
			#40;
		end
	endtask
endmodule // ucrs_peer

// [sim/ucrs_top_tb.sv]
// Register-level bench of the clocked serial port against the serial peer
`timescale 1ns/100ps
`include "ucrs_consts.svh"
module ucrs_top_tb;
	logic                clk = 1'b0;
	logic                rst_n = 1'b0;
	logic [2:0]          addr = 3'h0;
	logic [7:0]          wdata = 8'h00;
	logic                wr = 1'b0;
	logic                rd = 1'b0;
	logic                core_sleep = 1'b0;
	logic [7:0]          rdata;
	logic                rx_irq;
	logic                tx_irq;
	logic                wake;
	ucrs_pkg::ucrs_pin_t ck_pin;
	ucrs_pkg::ucrs_pin_t dt_pin;
	wire logic           clk_wire;
	wire logic           dat_wire;
	logic [7:0]          d;
	logic [8:0]          w;
	logic [7:0]          exp_rst [8] = '{8'h00, 8'h00, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'h20};
	int                  num_errors = 0;
	int                  check_count = 0;
	int                  n;

	always #12.5 clk = ~clk;

	ucrs_top #(.DIV_W(16)) i_dut (
		.clk                 (clk),
		.rst_n               (rst_n),
		.addr                (addr),
		.wdata               (wdata),
		.wr                  (wr),
		.rd                  (rd),
		.rdata               (rdata),
		.core_sleep          (core_sleep),
		.shift_clock_pin_in  (clk_wire),
		.shift_clock_pin     (ck_pin),
		.receive_data_pin_in (dat_wire),
		.receive_data_pin    (dt_pin),
		.rx_irq              (rx_irq),
		.tx_irq              (tx_irq),
		.wake_request        (wake)
	);

	ucrs_peer i_peer (
		.dev_clk_out (ck_pin.out),
		.dev_clk_oe  (ck_pin.oe),
		.dev_dat_out (dt_pin.out),
		.dev_dat_oe  (dt_pin.oe),
		.clk_wire    (clk_wire),
		.dat_wire    (dat_wire)
	);

	task automatic complete_run;
		if (num_errors == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
		check_count++;
		if (g !== e) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic chk1(input string nm, input logic e, input logic g);
		check_count++;
		if (g !== e) begin
			num_errors++;
			$display("[FAIL] %s expected %b seen %b", nm, e, g);
		end
	endtask

	task automatic chk16(input string nm, input logic [15:0] e, input logic [15:0] g);
		check_count++;
		if (g !== e) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Both tasks return just after the sampling edge has landed
	task automatic wr_reg(input logic [2:0] a, input logic [7:0] v);
		@(posedge clk);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		#1;
	endtask

	task automatic rd_reg(input logic [2:0] a, output logic [7:0] v);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 v = rdata;
	endtask

	// Waits for the receive or transmit request, bounded
	task automatic wait_irq(input logic sel);
		int k;
		k = 0;
		while ((sel ? tx_irq : rx_irq) !== 1'b1) begin
			if (k == 2000) begin
				num_errors++;
				$display("[FAIL] irq wait expected 1 seen 0");
				complete_run();
			end
			k++;
			@(posedge clk);
		end
		#1;
	endtask

	initial begin
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			rd_reg(3'(i), d);
			chk8("reset value", exp_rst[i], d);
		end
		// Master single-word reception
		i_peer.load(9'h0a5, 9'h000, 9'h000, 8);
		wr_reg(`UCRS_ADDR_DIV_LO, 8'h07);
		wr_reg(`UCRS_ADDR_TXSTA, 8'h90);
		wr_reg(`UCRS_ADDR_IRQ, 8'h01);
		wr_reg(`UCRS_ADDR_RCSTA, 8'ha0);
		chk1("master clock oe", 1'b1, ck_pin.oe);
		wait_irq(1'b0);
		chk1("rx irq", 1'b1, rx_irq);
		n = 0;
		d[0] = ck_pin.out;
		repeat (100) begin
			@(posedge clk);
			#1 if (ck_pin.out !== d[0])
				n++;
			d[0] = ck_pin.out;
		end
		chk8("clock edges after word", 8'h00, 8'(n));
		rd_reg(`UCRS_ADDR_RCSTA, d);
		chk8("status errors", 8'h00, d & 8'h07);
		rd_reg(`UCRS_ADDR_RCDATA, d);
		chk8("single word", 8'ha5, d);
		chk1("rx irq after read", 1'b0, rx_irq);
		// Wide divisor: each clock phase lasts the divisor plus one cycle
		wr_reg(`UCRS_ADDR_BAUD, 8'h08);
		wr_reg(`UCRS_ADDR_DIV_HI, 8'h01);
		wr_reg(`UCRS_ADDR_DIV_LO, 8'h00);
		wr_reg(`UCRS_ADDR_RCSTA, 8'ha0);
		n = 0;
		while (ck_pin.out !== 1'b1 && n < 300) begin
			@(posedge clk);
			#1 n++;
		end
		n = 0;
		while (ck_pin.out === 1'b1 && n < 300) begin
			@(posedge clk);
			#1 n++;
		end
		chk16("wide half period", 16'h0101, 16'(n));
		wr_reg(`UCRS_ADDR_RCSTA, 8'h80);
		wr_reg(`UCRS_ADDR_BAUD, 8'h00);
		wr_reg(`UCRS_ADDR_DIV_LO, 8'h07);
		// Continuous nine-bit reception with both enables, then overrun
		i_peer.load(9'h13c, 9'h0c3, 9'h155, 9);
		wr_reg(`UCRS_ADDR_RCSTA, 8'hc0);
		wr_reg(`UCRS_ADDR_RCSTA, 8'hf0);
		wait_irq(1'b0);
		rd_reg(`UCRS_ADDR_RCSTA, d);
		chk8("ninth bit", 8'h01, d & 8'h07);
		rd_reg(`UCRS_ADDR_RCDATA, d);
		chk8("first word", 8'h3c, d);
		wait_irq(1'b0);
		repeat (300) @(posedge clk);
		rd_reg(`UCRS_ADDR_RCSTA, d);
		chk8("overrun", 8'h02, d & 8'h06);
		rd_reg(`UCRS_ADDR_RCDATA, d);
		chk8("second word kept", 8'hc3, d);
		wr_reg(`UCRS_ADDR_RCSTA, 8'hc0);
		rd_reg(`UCRS_ADDR_RCSTA, d);
		chk8("errors cleared", 8'h00, d & 8'h06);
		// Slave transmission of two words across sleep
		wr_reg(`UCRS_ADDR_TXSTA, 8'h10);
		wr_reg(`UCRS_ADDR_RCSTA, 8'h80);
		wr_reg(`UCRS_ADDR_IRQ, 8'h02);
		chk1("slave clock oe", 1'b0, ck_pin.oe);
		chk1("empty irq", 1'b1, tx_irq);
		wr_reg(`UCRS_ADDR_TXDATA, 8'h11);
		chk1("empty after write", 1'b0, tx_irq);
		repeat (20) @(posedge clk);
		#1 chk1("no shift before enable", 1'b0, dt_pin.oe);
		wr_reg(`UCRS_ADDR_TXSTA, 8'h30);
		repeat (3) @(posedge clk);
		#1 chk1("shifter driving", 1'b1, dt_pin.oe);
		chk1("empty after load", 1'b1, tx_irq);
		wr_reg(`UCRS_ADDR_TXDATA, 8'h5a);
		@(posedge clk);
		core_sleep <= 1'b1;
		repeat (2) @(posedge clk);
		#1 chk1("second waits", 1'b0, tx_irq);
		chk1("no wake yet", 1'b0, wake);
		i_peer.slave_frame(8, w);
		chk8("first word out", 8'h11, w[7:0]);
		wait_irq(1'b1);
		chk1("wake", 1'b1, wake);
		rd_reg(`UCRS_ADDR_TXSTA, d);
		chk8("shifter busy", 8'h30, d);
		i_peer.slave_frame(8, w);
		chk8("second word out", 8'h5a, w[7:0]);
		repeat (10) @(posedge clk);
		rd_reg(`UCRS_ADDR_TXSTA, d);
		chk8("shifter empty", 8'h32, d);
		@(posedge clk);
		core_sleep <= 1'b0;
		// Nine-bit slave transmission: ninth bit goes out after the data byte
		wr_reg(`UCRS_ADDR_TXSTA, 8'h71);
		wr_reg(`UCRS_ADDR_TXDATA, 8'h96);
		i_peer.slave_frame(9, w);
		chk8("nine-bit word out", 8'h96, w[7:0]);
		chk1("ninth bit out", 1'b1, w[8]);
		complete_run();
	end
endmodule // ucrs_top_tb
